// ### logic/usc_pkg.sv
/*
 * constants, field positions, states and carriers of the serial port
 * status and control block.
 * assumes a 100 MHz hclk and a 32-bit AHB-Lite register bus.
 */
package usc_pkg;
    localparam int CLK_HZ     = 100_000_000;
    localparam int BAUD_HZ    = 115_200;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
    localparam int IR_NUM     = 3;
    localparam int IR_DEN     = 16;
    localparam int TX_DEPTH   = 4;
    localparam int DATA_BITS  = 8;
    localparam int BREAK_BITS = 12;

    localparam logic [7:0] OFS_STA   = 8'h00;
    localparam logic [7:0] OFS_MODE  = 8'h04;
    localparam logic [7:0] OFS_DATA  = 8'h08;
    localparam logic [7:0] OFS_ISTAT = 8'h0c;
    localparam logic [7:0] OFS_ICLR  = 8'h10;
    localparam logic [7:0] OFS_IEN   = 8'h14;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    localparam int B_ADM    = 24;
    localparam int B_ADDR   = 16;
    localparam int B_TXSEL  = 14;
    localparam int B_INV    = 13;
    localparam int B_RXEN   = 12;
    localparam int B_BRK    = 11;
    localparam int B_TXEN   = 10;
    localparam int B_TXBF   = 9;
    localparam int B_TX_SHIFT_EMPTY   = 8;
    localparam int B_RECEIVER_IDLE_FLAG  = 4;
    localparam int B_FERR   = 2;
    localparam int B_RXDA   = 0;
    localparam int B_ON     = 15;
    localparam int B_INFRARED_ENCODE_ENABLE   = 12;

    localparam logic [1:0] TXSEL_ROOM  = 2'h0;
    localparam logic [1:0] TXSEL_DONE  = 2'h1;
    localparam logic [1:0] TXSEL_EMPTY = 2'h2;

    localparam int I_TX   = 0;
    localparam int I_RX   = 1;
    localparam int I_ADDR = 2;
    localparam int I_BRK  = 3;
    localparam int IRQ_W  = 4;

    typedef enum logic [1:0] {USC_IDLE, USC_START, USC_BITS, USC_STOP} usc_line_e;

    typedef struct packed {
        logic       adm;
        logic [7:0] addr;
        logic [1:0] txsel;
        logic       inv;
        logic       rxen;
        logic       brk;
        logic       txen;
    } usc_ctl_s;

    typedef struct packed {
        logic on;
        logic infrared_encode_enable;
    } usc_mode_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       ferr;
    } usc_rxchar_s;
endpackage

// ### logic/usc_sync.sv
/*
 * three-flop synchroniser for one pin level; the output moves only
 * once the second and third stages agree.
 * assumes the pin is asynchronous to hclk.
 */
`timescale 1ns/1ps
module usc_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin,
    output logic      level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic o;
    } usc_sync_s;

    usc_sync_s s, next_s;

    always_comb begin
        next_s    = s;
        next_s.s1 = pin;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        if (s.s2 == s.s3) begin
            next_s.o = s.s3;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            s <= next_s;
        end
    end

    assign level = s.o;
endmodule // usc_sync

// ### logic/usc_rx.sv
/*
 * receive deserialiser: start, eight data bits lsb first, stop.
 * assumes rx_lvl is already synchronised to hclk.
 */
`timescale 1ns/1ps
module usc_rx #(
    parameter int BIT_CYCLES = usc_pkg::BIT_CYCLES
) (
    input  wire logic           hclk,
    input  wire logic           hresetn,
    input  wire logic           enable,
    input  wire logic           rx_lvl,
    output usc_pkg::usc_rxchar_s rx_char,
    output logic                idle
);
    localparam int CYW = $clog2(BIT_CYCLES);
    localparam logic [CYW-1:0] CYC_LAST = CYW'(BIT_CYCLES - 1);
    localparam logic [CYW-1:0] CYC_HALF = CYW'(BIT_CYCLES / 2);
    localparam logic [2:0]     BIT_LAST = 3'(usc_pkg::DATA_BITS - 1);

    typedef struct packed {
        usc_pkg::usc_line_e   st;
        logic [CYW-1:0]       cyc;
        logic [2:0]           bitn;
        logic [7:0]           sh;
        usc_pkg::usc_rxchar_s chr;
    } usc_rxst_s;

    usc_rxst_s s, next_s;

    always_comb begin
        next_s           = s;
        next_s.chr.valid = 1'b0;
        next_s.cyc       = s.cyc + 1'b1;
        if (!enable) begin
            next_s.st = usc_pkg::USC_IDLE;
        end else begin
            case (s.st)
                usc_pkg::USC_IDLE: begin
                    next_s.cyc = '0;
                    if (!rx_lvl) begin
                        next_s.st = usc_pkg::USC_START;
                    end
                end
                usc_pkg::USC_START: begin
                    // half a bit in, a high line means a glitch
                    if (s.cyc == CYC_HALF) begin
                        next_s.cyc  = '0;
                        next_s.bitn = '0;
                        next_s.st   = rx_lvl ? usc_pkg::USC_IDLE : usc_pkg::USC_BITS;
                    end
                end
                usc_pkg::USC_BITS: begin
                    if (s.cyc == CYC_LAST) begin
                        next_s.cyc  = '0;
                        next_s.sh   = {rx_lvl, s.sh[7:1]};
                        next_s.bitn = s.bitn + 1'b1;
                        if (s.bitn == BIT_LAST) begin
                            next_s.st = usc_pkg::USC_STOP;
                        end
                    end
                end
                default: begin
                    if (s.cyc == CYC_LAST) begin
                        next_s.chr = '{valid: 1'b1, data: s.sh, ferr: !rx_lvl};
                        next_s.st  = usc_pkg::USC_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rx_char = s.chr;
    assign idle    = (s.st == usc_pkg::USC_IDLE);

    property p_rx_off;
        @(posedge hclk) disable iff (!hresetn)
        !enable |=> (s.st == usc_pkg::USC_IDLE) && !rx_char.valid;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx not idle while disabled");
endmodule // usc_rx

// ### logic/usc_uart_status_control.sv
/*
 * serial port status and control: register slave, transmit buffer and
 * shifter with break and infrared output, receive address matching and
 * the interrupt status, clear and enable registers.
 * assumes one AHB-Lite master and that hready is this slave's hreadyout.
 */
`timescale 1ns/1ps
module usc_uart_status_control #(
    parameter int BIT_CYCLES = usc_pkg::BIT_CYCLES,
    parameter int TX_DEPTH   = usc_pkg::TX_DEPTH
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    output logic             serial_out_pin,
    output logic             serial_out_oe_n,
    input  wire logic        serial_in_pin
);
    localparam int CYW = $clog2(BIT_CYCLES);
    localparam int PW  = $clog2(TX_DEPTH);
    localparam int CW  = $clog2(TX_DEPTH + 1);
    localparam logic [CYW-1:0] CYC_LAST = CYW'(BIT_CYCLES - 1);
    localparam logic [CYW-1:0] IR_CYC   =
        CYW'(BIT_CYCLES * usc_pkg::IR_NUM / usc_pkg::IR_DEN);
    localparam logic [CW-1:0]  CNT_FULL  = CW'(TX_DEPTH);
    localparam logic [PW-1:0]  PTR_LAST  = PW'(TX_DEPTH - 1);
    localparam logic [3:0]     DATA_LAST = 4'(usc_pkg::DATA_BITS - 1);
    localparam logic [3:0]     BRK_LAST  = 4'(usc_pkg::BREAK_BITS - 1);

    if (TX_DEPTH < 2 || BIT_CYCLES < usc_pkg::IR_DEN) begin : g_check
        $error("usc_uart_status_control: TX_DEPTH or BIT_CYCLES too small");
    end

    typedef struct packed {
        usc_pkg::usc_ctl_s          ctl;
        usc_pkg::usc_mode_s         mode;
        logic [TX_DEPTH-1:0][7:0]   q;
        logic [PW-1:0]              rd;
        logic [PW-1:0]              wr;
        logic [CW-1:0]              cnt;
        usc_pkg::usc_line_e         txs;
        logic [CYW-1:0]             cyc;
        logic [3:0]                 bitn;
        logic [11:0]                sh;
        logic                       is_brk;
        logic                       line;
        logic [7:0]                 rxd;
        logic                       rxda;
        logic                       ferr;
        logic                       matched;
        logic [usc_pkg::IRQ_W-1:0]  ist;
        logic [usc_pkg::IRQ_W-1:0]  ien;
        logic                       irq;
        logic                       out;
        logic                       oe_n;
        logic                       ap_rd;
        logic                       ap_wr;
        logic [7:0]                 ap_addr;
        logic [31:0]                rdata;
        logic                       ready;
        logic                       resp;
    } usc_state_s;

    usc_state_s           s, next_s;
    logic                 rx_lvl;
    logic                 rx_idle;
    usc_pkg::usc_rxchar_s rx_char;

    function automatic logic [PW-1:0] usc_inc(input logic [PW-1:0] p);
        return (p == PTR_LAST) ? '0 : p + 1'b1;
    endfunction

    usc_sync #(
        .RST_VAL (1'b1)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (serial_in_pin),
        .level   (rx_lvl)
    );

    usc_rx #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_rx (
        .hclk    (hclk),
        .hresetn (hresetn),
        .enable  (s.ctl.rxen && s.mode.on),
        .rx_lvl  (rx_lvl),
        .rx_char (rx_char),
        .idle    (rx_idle)
    );

    logic                      tx_empty;
    logic                      tx_full;
    logic                      tx_shift_empty;
    logic                      tx_active;
    logic                      bit_end;
    logic                      ir_pulse;
    logic                      push;
    logic                      pop;
    logic                      tx_cond;
    logic [usc_pkg::IRQ_W-1:0] ev;
    logic [31:0]               sta_word;
    logic [31:0]               rd_word;

    always_comb begin
        tx_empty  = (s.cnt == '0);
        tx_full   = (s.cnt == CNT_FULL);
        tx_shift_empty      = tx_empty && (s.txs == usc_pkg::USC_IDLE);
        tx_active = s.ctl.txen && s.mode.on;
        bit_end   = (s.cyc == CYC_LAST);
        ir_pulse  = (s.txs != usc_pkg::USC_IDLE) && !s.line && (s.cyc < IR_CYC);
        // unimplemented upper bits stay zero from the default
        sta_word                          = '0;
        sta_word[usc_pkg::B_ADM]          = s.ctl.adm;
        sta_word[usc_pkg::B_ADDR +: 8]    = s.ctl.addr;
        sta_word[usc_pkg::B_TXSEL +: 2]   = s.ctl.txsel;
        sta_word[usc_pkg::B_INV]          = s.ctl.inv;
        sta_word[usc_pkg::B_RXEN]         = s.ctl.rxen;
        sta_word[usc_pkg::B_BRK]          = s.ctl.brk;
        sta_word[usc_pkg::B_TXEN]         = s.ctl.txen;
        sta_word[usc_pkg::B_TXBF]         = tx_full;
        sta_word[usc_pkg::B_TX_SHIFT_EMPTY]         = tx_shift_empty;
        sta_word[usc_pkg::B_RECEIVER_IDLE_FLAG]        = rx_idle;
        sta_word[usc_pkg::B_FERR]         = s.ferr;
        sta_word[usc_pkg::B_RXDA]         = s.rxda;
        rd_word = '0;
        if (s.ap_addr == usc_pkg::OFS_STA) begin
            rd_word = sta_word;
        end else if (s.ap_addr == usc_pkg::OFS_MODE) begin
            rd_word[usc_pkg::B_ON]   = s.mode.on;
            rd_word[usc_pkg::B_INFRARED_ENCODE_ENABLE] = s.mode.infrared_encode_enable;
        end else if (s.ap_addr == usc_pkg::OFS_DATA) begin
            rd_word[7:0] = s.rxd;
        end else if (s.ap_addr == usc_pkg::OFS_ISTAT) begin
            rd_word[usc_pkg::IRQ_W-1:0] = s.ist;
        end else if (s.ap_addr == usc_pkg::OFS_IEN) begin
            rd_word[usc_pkg::IRQ_W-1:0] = s.ien;
        end
        case (s.ctl.txsel)
            usc_pkg::TXSEL_EMPTY: tx_cond = tx_empty;
            usc_pkg::TXSEL_DONE:  tx_cond = tx_shift_empty;
            usc_pkg::TXSEL_ROOM:  tx_cond = !tx_full;
            default:              tx_cond = 1'b0;
        endcase

        next_s = s;
        push   = 1'b0;
        pop    = 1'b0;
        ev     = '0;
        ev[usc_pkg::I_TX] = tx_cond;

        // transmit shifter
        next_s.cyc = s.cyc + 1'b1;
        case (s.txs)
            usc_pkg::USC_IDLE: begin
                next_s.cyc  = '0;
                next_s.line = 1'b1;
                if (tx_active && s.ctl.brk) begin
                    next_s.is_brk = 1'b1;
                    next_s.sh     = '0;
                    next_s.txs    = usc_pkg::USC_START;
                    next_s.line   = 1'b0;
                end else if (tx_active && !tx_empty) begin
                    pop           = 1'b1;
                    next_s.is_brk = 1'b0;
                    next_s.sh     = {4'h0, s.q[s.rd]};
                    next_s.txs    = usc_pkg::USC_START;
                    next_s.line   = 1'b0;
                end
            end
            usc_pkg::USC_START: begin
                if (bit_end) begin
                    next_s.cyc  = '0;
                    next_s.bitn = '0;
                    next_s.line = s.sh[0];
                    next_s.txs  = usc_pkg::USC_BITS;
                end
            end
            usc_pkg::USC_BITS: begin
                if (bit_end) begin
                    next_s.cyc = '0;
                    if (s.bitn == (s.is_brk ? BRK_LAST : DATA_LAST)) begin
                        next_s.line = 1'b1;
                        next_s.txs  = usc_pkg::USC_STOP;
                    end else begin
                        next_s.bitn = s.bitn + 1'b1;
                        next_s.sh   = {1'b0, s.sh[11:1]};
                        next_s.line = s.sh[1];
                    end
                end
            end
            default: begin
                if (bit_end) begin
                    next_s.txs = usc_pkg::USC_IDLE;
                    if (s.is_brk) begin
                        next_s.ctl.brk    = 1'b0;
                        ev[usc_pkg::I_BRK] = 1'b1;
                    end
                end
            end
        endcase

        // receive side, address filter first
        if (!s.ctl.adm) begin
            next_s.matched = 1'b0;
        end
        if (rx_char.valid) begin
            if (!s.ctl.adm || s.matched) begin
                next_s.rxd  = rx_char.data;
                next_s.ferr = rx_char.ferr;
                ev[usc_pkg::I_RX] = 1'b1;
            end else if (rx_char.data == s.ctl.addr) begin
                next_s.rxd     = rx_char.data;
                next_s.ferr    = rx_char.ferr;
                next_s.matched = 1'b1;
                ev[usc_pkg::I_RX]   = 1'b1;
                ev[usc_pkg::I_ADDR] = 1'b1;
            end
        end

        // bus data phase; writes land after the shifter so they win
        next_s.ready = 1'b1;
        next_s.ap_rd = 1'b0;
        next_s.ap_wr = 1'b0;
        if (s.ap_rd) begin
            next_s.rdata = rd_word;
            if (s.ap_addr == usc_pkg::OFS_DATA) begin
                next_s.rxda = 1'b0;
            end
        end
        if (s.ap_wr) begin
            if (s.ap_addr == usc_pkg::OFS_STA) begin
                next_s.ctl.adm   = hwdata[usc_pkg::B_ADM];
                next_s.ctl.addr  = hwdata[usc_pkg::B_ADDR +: 8];
                next_s.ctl.txsel = hwdata[usc_pkg::B_TXSEL +: 2];
                next_s.ctl.inv   = hwdata[usc_pkg::B_INV];
                next_s.ctl.rxen  = hwdata[usc_pkg::B_RXEN];
                next_s.ctl.brk   = hwdata[usc_pkg::B_BRK];
                next_s.ctl.txen  = hwdata[usc_pkg::B_TXEN];
            end else if (s.ap_addr == usc_pkg::OFS_MODE) begin
                next_s.mode.on   = hwdata[usc_pkg::B_ON];
                next_s.mode.infrared_encode_enable = hwdata[usc_pkg::B_INFRARED_ENCODE_ENABLE];
            end else if (s.ap_addr == usc_pkg::OFS_DATA) begin
                // a write to a full buffer is dropped
                push = tx_active && !tx_full;
            end else if (s.ap_addr == usc_pkg::OFS_ICLR) begin
                next_s.ist = s.ist & ~hwdata[usc_pkg::IRQ_W-1:0];
            end else if (s.ap_addr == usc_pkg::OFS_IEN) begin
                next_s.ien = hwdata[usc_pkg::IRQ_W-1:0];
            end
        end
        if (rx_char.valid && (ev[usc_pkg::I_RX])) begin
            next_s.rxda = 1'b1;
        end
        if (hsel && hready && htrans[1]) begin
            next_s.ap_addr = haddr[7:0];
            next_s.ap_rd   = !hwrite;
            next_s.ap_wr   = hwrite && (hsize == usc_pkg::HSIZE_WORD);
            // one wait state because read data is registered into rdata in the data phase
            next_s.ready   = hwrite;
        end

        // buffer bookkeeping
        if (push) begin
            next_s.q[s.wr] = hwdata[7:0];
            next_s.wr      = usc_inc(s.wr);
        end
        if (pop) begin
            next_s.rd = usc_inc(s.rd);
        end
        next_s.cnt = s.cnt + CW'(push) - CW'(pop);
        if (!s.ctl.txen) begin
            next_s.txs  = usc_pkg::USC_IDLE;
            next_s.line = 1'b1;
            next_s.cnt  = '0;
            next_s.rd   = '0;
            next_s.wr   = '0;
        end

        // set wins over a clear in the same cycle
        next_s.ist  = next_s.ist | ev;
        next_s.irq  = |(next_s.ist & next_s.ien);
        next_s.out  = s.mode.infrared_encode_enable ? (s.ctl.inv ^ ir_pulse)
                                  : (s.line ^ s.ctl.inv);
        next_s.oe_n = !tx_active;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s       <= '0;
            s.line  <= 1'b1;
            s.out   <= 1'b1;
            s.oe_n  <= 1'b1;
            s.ready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign hrdata          = s.rdata;
    assign hreadyout       = s.ready;
    assign hresp           = s.resp;
    assign irq             = s.irq;
    assign serial_out_pin  = s.out;
    assign serial_out_oe_n = s.oe_n;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_abort;
        !s.ctl.txen |=> (s.cnt == '0) && (s.txs == usc_pkg::USC_IDLE);
    endproperty
    a_abort: assert property (p_abort) else $error("tx not flushed");

    property p_brk_clear;
        (s.txs == usc_pkg::USC_STOP && s.is_brk && bit_end && s.ctl.txen && !s.ap_wr)
            |=> !s.ctl.brk;
    endproperty
    a_brk_clear: assert property (p_brk_clear) else $error("break bit kept");

    property p_brk_zero;
        (s.txs == usc_pkg::USC_BITS && s.is_brk) |-> !s.line && (s.bitn <= BRK_LAST);
    endproperty
    a_brk_zero: assert property (p_brk_zero) else $error("break bit not zero");

    property p_irq_empty;
        (s.ctl.txsel == usc_pkg::TXSEL_EMPTY && s.cnt == '0) |=> s.ist[usc_pkg::I_TX];
    endproperty
    a_irq_empty: assert property (p_irq_empty) else $error("empty irq missed");

    property p_irq_done;
        (s.ctl.txsel == usc_pkg::TXSEL_DONE && tx_shift_empty) |=> s.ist[usc_pkg::I_TX];
    endproperty
    a_irq_done: assert property (p_irq_done) else $error("done irq missed");

    property p_irq_room;
        (s.ctl.txsel == usc_pkg::TXSEL_ROOM && s.cnt < CNT_FULL) |=> s.ist[usc_pkg::I_TX];
    endproperty
    a_irq_room: assert property (p_irq_room) else $error("room irq missed");

    property p_idle_plain;
        (!s.mode.infrared_encode_enable && s.ctl.inv && s.txs == usc_pkg::USC_IDLE) |=> !serial_out_pin;
    endproperty
    a_idle_plain: assert property (p_idle_plain) else $error("idle not low");

    property p_idle_ir;
        (s.mode.infrared_encode_enable && s.txs == usc_pkg::USC_IDLE) |=> serial_out_pin == $past(s.ctl.inv);
    endproperty
    a_idle_ir: assert property (p_idle_ir) else $error("ir idle wrong");

    property p_drive;
        (s.ctl.txen && s.mode.on) |=> !serial_out_oe_n;
    endproperty
    a_drive: assert property (p_drive) else $error("pin not driven");

    property p_full;
        (push && s.cnt == CNT_FULL - 1'b1 && !pop && s.ctl.txen) |=> tx_full;
    endproperty
    a_full: assert property (p_full) else $error("full flag late");

    property p_tx_shift_empty;
        (tx_active && !tx_empty && s.txs == usc_pkg::USC_IDLE && s.ctl.txen)
            |=> (s.txs == usc_pkg::USC_START) && !tx_shift_empty;
    endproperty
    a_tx_shift_empty: assert property (p_tx_shift_empty) else $error("shift-empty wrong");

    property p_upper_zero;
        (s.ap_rd && s.ap_addr == usc_pkg::OFS_STA) |=> (hrdata[31:25] == 7'h00) && hreadyout;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

    property p_addr_filter;
        (rx_char.valid && s.ctl.adm && !s.matched && rx_char.data != s.ctl.addr)
            |=> s.rxd == $past(s.rxd);
    endproperty
    a_addr_filter: assert property (p_addr_filter) else $error("char not filtered");
endmodule // usc_uart_status_control

// ### bench/usc_peer.sv
/*
 * remote serial peer: sends one framed byte on its line.
 * assumes the same bit length in hclk cycles as the design.
 */
`timescale 1ns/1ps
module usc_peer #(
    parameter int BIT_CYCLES = 16
) (
    input  wire logic hclk,
    output logic      line
);
    // mark level between frames, as a real peer would hold it
    initial line = 1'b1;
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line <= f[i];
            repeat (BIT_CYCLES) @(posedge hclk);
        end
    endtask
endmodule // usc_peer

// ### bench/usc_uart_status_control_tb_top.sv
/*
 * self-checking bench of the serial port status and control block.
 * assumes hready is tied to the slave's hreadyout.
 */
`timescale 1ns/1ps
module usc_uart_status_control_tb_top;
    localparam int BC = 16;
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, r, c, lfsr = 32'hc6fe;
    logic [1:0]  htrans = 2'h0;
    logic        hreadyout, hresp, irq, txd, oe_n, rxd;
    int          miscompares = 0, num_checks = 0;
    always #5 hclk = ~hclk;
    usc_uart_status_control #(.BIT_CYCLES(BC)) uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq), .serial_out_pin(txd), .serial_out_oe_n(oe_n),
        .serial_in_pin(rxd));
    usc_peer #(.BIT_CYCLES(BC)) peer (.hclk(hclk), .line(rxd));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, 8'h00, 0); check(r, 32'h110);
        check(hresp, 0);
        bus(0, 8'h20, 0); check(r, 0);
        // select code 11 never written: field kept below 2'h3
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            c = lfsr & 32'h01ff3000;
            bus(1, 8'h00, c | 32'hfe000000);
            bus(0, 8'h00, 0); check(r, c | 32'h110);
            check(txd, !c[13]);
        end
        bus(1, 8'h04, 32'h8000);
        bus(1, 8'h00, 32'h1400);
        // enable pin follows the control write by one registered stage
        repeat (2) @(posedge hclk);
        check(oe_n, 0);
        c = nxt(lfsr) & 32'hff;
        bus(1, 8'h08, c);
        bus(0, 8'h00, 0); check(r[8], 0);
        for (int i = 0; i < 50 && txd !== 1'b0; i++) @(posedge hclk);
        repeat (BC / 2) @(posedge hclk);
        for (int i = 0; i < 10; i++) begin
            check(txd, ({1'b1, c[7:0], 1'b0} >> i) & 32'h1);
            repeat (BC) @(posedge hclk);
        end
        bus(0, 8'h00, 0); check(r, 32'h1510);
        bus(1, 8'h14, 2);
        peer.send(8'h5a);
        repeat (2 * BC) @(posedge hclk);
        check(irq, 1);
        bus(0, 8'h08, 0); check(r[7:0], 8'h5a);
        // address mode: a foreign char is dropped, the match char gets through
        bus(1, 8'h00, 32'h01a51400);
        peer.send(8'h33);
        repeat (2 * BC) @(posedge hclk);
        bus(0, 8'h08, 0);
        check(r[7:0], 8'h5a);
        peer.send(8'ha5);
        repeat (2 * BC) @(posedge hclk);
        bus(0, 8'h08, 0);
        check(r[7:0], 8'ha5);
        bus(1, 8'h10, 2);
        @(posedge hclk);
        check(irq, 0);
        bus(1, 8'h14, 1);
        @(posedge hclk);
        check(irq, 1);
        // select 01: a char still shifting holds the interrupt off
        bus(1, 8'h00, 32'h4400);
        bus(1, 8'h08, 32'h3c);
        bus(1, 8'h10, 1);
        @(posedge hclk);
        check(irq, 0);
        repeat (11 * BC) @(posedge hclk);
        check(irq, 1);
        // select 10: a char left in the buffer holds it off
        bus(1, 8'h00, 32'h8400);
        bus(1, 8'h08, 32'hc3);
        bus(1, 8'h08, 32'h96);
        bus(1, 8'h10, 1);
        @(posedge hclk);
        check(irq, 0);
        repeat (11 * BC) @(posedge hclk);
        check(irq, 1);
        // break waits for the frame still on the line
        bus(1, 8'h00, 32'h0c00);
        repeat (32 * BC) @(posedge hclk);
        bus(0, 8'h00, 0); check(r, 32'h0510);
        // one char goes to the shifter, the rest fill the buffer
        for (int i = 0; i < 5; i++) bus(1, 8'h08, i);
        bus(0, 8'h00, 0);
        check(r[9:8], 2'h2);
        bus(1, 8'h00, 0);
        repeat (2) @(posedge hclk);
        check(oe_n, 1);
        bus(0, 8'h00, 0);
        check(r, 32'h110);
        bus(1, 8'h04, 32'h9000);
        bus(1, 8'h00, 32'h2000);
        repeat (2) @(posedge hclk);
        check(txd, 1);
        bus(1, 8'h00, 0);
        repeat (2) @(posedge hclk);
        check(txd, 0);
        conclude();
    end
endmodule // usc_uart_status_control_tb_top
